// *** rtl/panel_pkg.sv ***
package panel_pkg;

  // Dot clock: nominal pixel period and the half period made from aclk
  localparam int unsigned ACLK_PERIOD_NS = 10;
  localparam int unsigned DOT_PERIOD_NS = 30;
  // A half period is a least time, so it rounds up to whole aclk cycles
  localparam int unsigned DOT_HALF_CYC =
    (DOT_PERIOD_NS / 2 + ACLK_PERIOD_NS - 1) / ACLK_PERIOD_NS;

  // Line and frame composition, in dot clocks and line periods
  localparam int unsigned H_ACTIVE = 800;
  localparam int unsigned H_TOTAL = 1056;
  localparam int unsigned V_ACTIVE = 480;
  localparam int unsigned V_TOTAL = 525;
  localparam int unsigned HSYNC_MIN = 1;
  localparam int unsigned HSYNC_MAX = 40;
  localparam int unsigned VSYNC_MIN = 1;
  localparam int unsigned VSYNC_MAX = 20;

  // Data bus width and counter widths
  localparam int unsigned RGB_W = 24;
  localparam int unsigned HCNT_W = 11;
  localparam int unsigned VCNT_W = 10;

  // Register byte offsets on the control bus
  localparam logic [3:0] OFS_CTRL = 4'h0;
  localparam logic [3:0] OFS_HTIM = 4'h4;
  localparam logic [3:0] OFS_VTIM = 4'h8;
  localparam logic [3:0] OFS_STAT = 4'hC;

  // Control register fields
  localparam int unsigned CTRL_RUN = 0;
  localparam int unsigned CTRL_STANDBY_SEL = 1;
  localparam int unsigned CTRL_HPOL = 2;
  localparam int unsigned CTRL_VPOL = 3;
  localparam int unsigned CTRL_MODE_LSB = 4;

  // Timing register fields: sync width low, back porch high
  localparam int unsigned TIM_SYNC_LSB = 0;
  localparam int unsigned TIM_BACK_LSB = 16;

  // Status register fields
  localparam int unsigned STAT_RUN = 0;
  localparam int unsigned STAT_ACTIVE = 1;
  localparam int unsigned STAT_FRAME_LSB = 8;
  localparam int unsigned STAT_LINE_LSB = 16;

  // Values after reset
  localparam logic [31:0] CTRL_RST = 32'h0000_0000;
  localparam logic [5:0] HSYNC_RST = 6'h14;
  localparam logic [9:0] HBACK_RST = 10'h02E;
  localparam logic [5:0] VSYNC_RST = 6'h0A;
  localparam logic [9:0] VBACK_RST = 10'h017;

  // AXI response codes
  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

  // Colour depth on the data bus
  typedef enum logic [1:0] {MODE_24, MODE_18, MODE_16, MODE_RSVD} color_mode_t;

  // Place a 24-bit pixel on the low lines for the chosen depth
  function automatic logic [23:0] pack_pixel(input logic [23:0] px, input color_mode_t m);
    logic [23:0] r;
    r = px;
    unique case (m)
      MODE_18: r = {6'h00, px[23:18], px[15:10], px[7:2]};
      MODE_16: r = {8'h00, px[23:19], px[15:10], px[7:3]};
      default: r = px;
    endcase
    return r;
  endfunction : pack_pixel

endpackage : panel_pkg

// *** rtl/rgb_link_if.sv ***
`timescale 1ns/10ps
interface rgb_link_if;
  // Pixel bus and control lines between driver and panel
  logic [23:0] rgb_data;
  logic dot_clock;
  logic standby_select;
  logic line_sync;
  logic frame_sync;
  logic pixel_valid_strobe;

  // Timing driver end
  modport driver (
    output rgb_data, dot_clock, standby_select, line_sync, frame_sync, pixel_valid_strobe
  );
  // Panel end
  modport panel (
    input rgb_data, dot_clock, standby_select, line_sync, frame_sync, pixel_valid_strobe
  );
endinterface : rgb_link_if

// *** rtl/sync2.sv ***
`timescale 1ns/10ps
module sync2 #(
  parameter int unsigned W = 1
) (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Asynchronous in, synchronised out
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  // First stage, read only by the second
  logic [W-1:0] meta_r;

  // Two flops against metastability
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      meta_r <= '0;
      q <= '0;
    end else begin
      meta_r <= d;
      q <= meta_r;
    end
  end
endmodule : sync2

// *** rtl/rgb_panel_rx.sv ***
`timescale 1ns/10ps
module rgb_panel_rx
  import panel_pkg::*;
(
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Link from the driver
  rgb_link_if.panel link,
  // Sync polarity expected from the driver
  input wire logic hsync_active_high,
  input wire logic vsync_active_high,
  // Received pixel stream
  output logic [23:0] pixel_out,
  output logic pixel_out_valid,
  output logic [HCNT_W-1:0] pixel_x,
  output logic [VCNT_W-1:0] pixel_y,
  output logic line_start,
  output logic frame_start,
  output logic display_on
);
  // All link lines pass the same two flops, so they stay aligned
  logic [RGB_W+4:0] raw;
  logic [RGB_W+4:0] syn;
  logic dot_prev_r;
  logic hs_prev_r;
  logic vs_prev_r;
  logic dot_rise;
  logic hs_act;
  logic vs_act;
  logic de_s;

  assign raw = {link.rgb_data, link.dot_clock, link.standby_select,
                link.line_sync, link.frame_sync, link.pixel_valid_strobe};

  // Two-flop synchroniser for every link input
  sync2 #(.W(RGB_W + 5)) u_sync (
    .aclk(aclk),
    .aresetn(aresetn),
    .d(raw),
    .q(syn)
  );

  assign de_s = syn[0];
  // Sync lines compared against the expected polarity
  assign vs_act = syn[1] ~^ vsync_active_high;
  assign hs_act = syn[2] ~^ hsync_active_high;
  // Rising dot clock edge is where data is latched
  assign dot_rise = syn[4] & ~dot_prev_r;

  // Dot clock history every cycle, sync history stepped only on rising dot clock edges
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      dot_prev_r <= 1'b0;
      hs_prev_r <= 1'b0;
      vs_prev_r <= 1'b0;
    end else begin
      dot_prev_r <= syn[4];
      if (dot_rise) begin
        hs_prev_r <= hs_act;
        vs_prev_r <= vs_act;
      end
    end
  end

  // Standby select low holds the panel in standby
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      display_on <= 1'b0;
    end else begin
      display_on <= syn[3];
    end
  end

  // Sync leading edges mark line and frame starts
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      line_start <= 1'b0;
      frame_start <= 1'b0;
    end else begin
      line_start <= dot_rise & hs_act & ~hs_prev_r;
      frame_start <= dot_rise & vs_act & ~vs_prev_r;
    end
  end

  // Pixel latch and position tracking on the dot clock
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pixel_out <= 24'h00_0000;
      pixel_out_valid <= 1'b0;
      pixel_x <= '0;
      pixel_y <= '0;
    end else begin
      pixel_out_valid <= 1'b0;
      if (dot_rise) begin
        if (vs_act && !vs_prev_r) begin
          // New frame: restart the line count
          pixel_y <= '0;
          pixel_x <= '0;
        end else if (hs_act && !hs_prev_r && pixel_x != '0) begin
          // Only lines that carried pixels advance the row
          pixel_y <= pixel_y + 1'b1;
          pixel_x <= '0;
        end
        if (de_s && syn[3]) begin
          // Standby drops pixels rather than queueing them
          pixel_out <= syn[RGB_W+4:5];
          pixel_out_valid <= 1'b1;
          pixel_x <= pixel_x + 1'b1;
        end
      end
    end
  end
endmodule : rgb_panel_rx

// *** rtl/rgb_timing_drv.sv ***
`timescale 1ns/10ps
// What this block does
// - Driver supplies dot clock at 25 MHz (40 ns period)
// - Dot clock is a 50 percent square wave
// - Panel latches data and times on dot clock
// - 24 data lines plus five control lines
// - Standby select low means standby, high on
// - Line period totals 1056 dot clocks
// - Line sync width from 1 to 40
// - Back porch fills line to 1056 clocks
// - Horizontal porches centre the image
// - Horizontal timing fixed while display runs
// - Frame period totals 525 line periods
// - Frame sync width from 1 to 20 lines
// - Vertical back porch completes the frame
// - Vertical porches centre image, fixed while running
// - Frame sync starts every frame
// - Line sync starts every line
// - Active area 800 by 480 pixels
// - Red high, green middle, blue low byte
module rgb_timing_drv
  import panel_pkg::*;
#(
  parameter int unsigned HALF_CYC = DOT_HALF_CYC
) (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // AXI4-Lite write address
  input wire logic [3:0] s_awaddr,
  input wire logic s_awvalid,
  output logic s_awready,
  // AXI4-Lite write data
  input wire logic [31:0] s_wdata,
  input wire logic [3:0] s_wstrb,
  input wire logic s_wvalid,
  output logic s_wready,
  // AXI4-Lite write response
  output logic [1:0] s_bresp,
  output logic s_bvalid,
  input wire logic s_bready,
  // AXI4-Lite read address
  input wire logic [3:0] s_araddr,
  input wire logic s_arvalid,
  output logic s_arready,
  // AXI4-Lite read data
  output logic [31:0] s_rdata,
  output logic [1:0] s_rresp,
  output logic s_rvalid,
  input wire logic s_rready,
  // Pixel source: pixel_in is taken while pixel_req is high
  input wire logic [23:0] pixel_in,
  output logic pixel_req,
  // Link to the panel
  rgb_link_if.driver link
);
  // Software registers
  logic [31:0] ctrl_r;
  logic [5:0] hsync_w_r;
  logic [9:0] hback_r;
  logic [5:0] vsync_w_r;
  logic [9:0] vback_r;
  // Bus handshake state
  logic aw_got_r;
  logic w_got_r;
  logic [3:0] awaddr_r;
  logic [31:0] wdata_r;
  // Dot clock divider and raster position
  logic [7:0] div_r;
  logic dot_r;
  logic fall_evt;
  logic [HCNT_W-1:0] h_r;
  logic [VCNT_W-1:0] v_r;
  logic [7:0] frame_cnt_r;
  logic run;
  logic h_act;
  logic v_act;
  logic [HCNT_W-1:0] h_act_lo;
  logic [VCNT_W-1:0] v_act_lo;
  color_mode_t mode;

  assign run = ctrl_r[CTRL_RUN];
  assign mode = color_mode_t'(ctrl_r[CTRL_MODE_LSB +: 2]);

  // Write channels are taken in either order, response after both
  assign s_awready = !aw_got_r && !s_bvalid;
  assign s_wready = !w_got_r && !s_bvalid;
  assign s_arready = !s_rvalid;

  // Write address and data capture
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_got_r <= 1'b0;
      w_got_r <= 1'b0;
      awaddr_r <= 4'h0;
      wdata_r <= 32'h0000_0000;
    end else begin
      if (s_awvalid && s_awready) begin
        aw_got_r <= 1'b1;
        awaddr_r <= s_awaddr;
      end
      if (s_wvalid && s_wready) begin
        w_got_r <= 1'b1;
        wdata_r <= s_wdata;
      end
      if (aw_got_r && w_got_r) begin
        aw_got_r <= 1'b0;
        w_got_r <= 1'b0;
      end
    end
  end

  // Register update and write response
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_r <= CTRL_RST;
      hsync_w_r <= HSYNC_RST;
      hback_r <= HBACK_RST;
      vsync_w_r <= VSYNC_RST;
      vback_r <= VBACK_RST;
      s_bvalid <= 1'b0;
      s_bresp <= RESP_OKAY;
    end else begin
      if (s_bvalid && s_bready) begin
        s_bvalid <= 1'b0;
      end
      if (aw_got_r && w_got_r) begin
        s_bvalid <= 1'b1;
        s_bresp <= RESP_OKAY;
        unique case (awaddr_r)
          OFS_CTRL: ctrl_r <= 32'(wdata_r[5:0]);
          OFS_HTIM: begin
            // Timing is frozen while running; illegal widths ignored
            if (!run && wdata_r[TIM_SYNC_LSB +: 6] >= 6'(HSYNC_MIN)
                && wdata_r[TIM_SYNC_LSB +: 6] <= 6'(HSYNC_MAX)
                && 11'(wdata_r[TIM_SYNC_LSB +: 6]) + 11'(wdata_r[TIM_BACK_LSB +: 10])
                   <= 11'(H_TOTAL - H_ACTIVE)) begin
              hsync_w_r <= wdata_r[TIM_SYNC_LSB +: 6];
              hback_r <= wdata_r[TIM_BACK_LSB +: 10];
            end
          end
          OFS_VTIM: begin
            if (!run && wdata_r[TIM_SYNC_LSB +: 6] >= 6'(VSYNC_MIN)
                && wdata_r[TIM_SYNC_LSB +: 6] <= 6'(VSYNC_MAX)
                // Sum kept at 11 bits so a large porch cannot wrap past the limit
                && 11'(wdata_r[TIM_SYNC_LSB +: 6]) + 11'(wdata_r[TIM_BACK_LSB +: 10])
                   <= 11'(V_TOTAL - V_ACTIVE)) begin
              vsync_w_r <= wdata_r[TIM_SYNC_LSB +: 6];
              vback_r <= wdata_r[TIM_BACK_LSB +: 10];
            end
          end
          OFS_STAT: s_bresp <= RESP_OKAY;
          default: s_bresp <= RESP_SLVERR;
        endcase
      end
    end
  end

  // Read response, one cycle after the address is taken
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_rvalid <= 1'b0;
      s_rdata <= 32'h0000_0000;
      s_rresp <= RESP_OKAY;
    end else begin
      if (s_rvalid && s_rready) begin
        s_rvalid <= 1'b0;
      end
      if (s_arvalid && s_arready) begin
        s_rvalid <= 1'b1;
        s_rresp <= RESP_OKAY;
        unique case (s_araddr)
          OFS_CTRL: s_rdata <= ctrl_r;
          OFS_HTIM: s_rdata <= {6'h00, hback_r, 10'h000, hsync_w_r};
          OFS_VTIM: s_rdata <= {6'h00, vback_r, 10'h000, vsync_w_r};
          OFS_STAT: s_rdata <= {6'h00, v_r, frame_cnt_r, 6'h00, h_act & v_act, run};
          default: begin
            s_rdata <= 32'h0000_0000;
            s_rresp <= RESP_SLVERR;
          end
        endcase
      end
    end
  end

  // Dot clock divider; equal halves give the square wave
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      div_r <= 8'h00;
      dot_r <= 1'b0;
    end else if (!run) begin
      // Clock parks low while stopped
      div_r <= 8'h00;
      dot_r <= 1'b0;
    end else if (div_r == 8'(HALF_CYC - 1)) begin
      div_r <= 8'h00;
      dot_r <= ~dot_r;
    end else begin
      div_r <= div_r + 8'h01;
    end
  end

  // Outputs move when the dot clock falls, far from the latch edge
  assign fall_evt = run && dot_r && div_r == 8'(HALF_CYC - 1);

  // Active window sits after sync plus back porch
  assign h_act_lo = HCNT_W'(hsync_w_r) + HCNT_W'(hback_r);
  assign v_act_lo = VCNT_W'(vsync_w_r) + vback_r;
  assign h_act = h_r >= h_act_lo && h_r < h_act_lo + HCNT_W'(H_ACTIVE);
  assign v_act = v_r >= v_act_lo && v_r < v_act_lo + VCNT_W'(V_ACTIVE);
  // Source pixel is consumed on the falling edge that puts it out
  assign pixel_req = fall_evt && h_act && v_act;

  // Raster counters: 1056 dots a line, 525 lines a frame
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      h_r <= '0;
      v_r <= '0;
      frame_cnt_r <= 8'h00;
    end else if (!run) begin
      h_r <= '0;
      v_r <= '0;
    end else if (fall_evt) begin
      if (h_r == HCNT_W'(H_TOTAL - 1)) begin
        h_r <= '0;
        if (v_r == VCNT_W'(V_TOTAL - 1)) begin
          v_r <= '0;
          frame_cnt_r <= frame_cnt_r + 8'h01;
        end else begin
          v_r <= v_r + 1'b1;
        end
      end else begin
        h_r <= h_r + 1'b1;
      end
    end
  end

  // Registered link outputs, updated on the falling dot edge
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      link.rgb_data <= 24'h00_0000;
      link.line_sync <= 1'b1;
      link.frame_sync <= 1'b1;
      link.pixel_valid_strobe <= 1'b0;
    end else if (!run) begin
      // Idle: syncs at inactive level, enable low
      link.line_sync <= ~ctrl_r[CTRL_HPOL];
      link.frame_sync <= ~ctrl_r[CTRL_VPOL];
      link.pixel_valid_strobe <= 1'b0;
    end else if (fall_evt) begin
      // Sync pulses open each line and frame, polarity from software
      link.line_sync <= (h_r < HCNT_W'(hsync_w_r)) ~^ ctrl_r[CTRL_HPOL];
      link.frame_sync <= (v_r < VCNT_W'(vsync_w_r)) ~^ ctrl_r[CTRL_VPOL];
      link.pixel_valid_strobe <= h_act && v_act;
      link.rgb_data <= (h_act && v_act) ? pack_pixel(pixel_in, mode) : 24'h00_0000;
    end
  end

  // Dot clock and standby select driven out
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      link.dot_clock <= 1'b0;
      link.standby_select <= 1'b0;
    end else begin
      // Pin takes the divider's next value, so it falls at the edge the data moves
      link.dot_clock <= run && (dot_r ^ (div_r == 8'(HALF_CYC - 1)));
      link.standby_select <= ctrl_r[CTRL_STANDBY_SEL];
    end
  end
endmodule : rgb_timing_drv

// *** sim/rgb_link_props.sv ***
`timescale 1ns/10ps
module rgb_link_props
  import panel_pkg::*;
#(
  parameter int unsigned HALF = 2
) (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Link lines
  input wire logic [23:0] rgb_data,
  input wire logic dot_clock,
  input wire logic standby_select,
  input wire logic line_sync,
  input wire logic frame_sync,
  input wire logic pixel_valid_strobe
);
  // Expected aclk spans of one line and of its active part
  localparam int LINE_CYC = H_TOTAL * 2 * HALF;
  localparam int ACT_CYC = H_ACTIVE * 2 * HALF;
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  logic [12:0] lcnt_r; // Cycles since line sync start
  logic [12:0] scnt_r; // Strobe cycles in this line
  logic seen_r; // A full line has started
  // Counters restart at each line sync; the first line sync after reset is not judged
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      lcnt_r <= '0;
      scnt_r <= '0;
      seen_r <= 1'b0;
    end else if ($fell(line_sync)) begin
      lcnt_r <= 13'h0001;
      scnt_r <= '0;
      seen_r <= 1'b1;
    end else begin
      lcnt_r <= lcnt_r + 13'h0001;
      scnt_r <= scnt_r + 13'(pixel_valid_strobe);
    end
  end
  // Dot clock phases, two aclk each
  sequence s_dot_hi; dot_clock [*2] ##1 !dot_clock; endsequence
  sequence s_dot_lo; (!dot_clock) [*2] ##1 dot_clock; endsequence
  sequence s_sync_one; (!line_sync) [*4] ##1 line_sync; endsequence
  property p_dot_high; $rose(dot_clock) |-> s_dot_hi; endproperty
  property p_dot_low; $fell(dot_clock) |-> s_dot_lo; endproperty
  property p_strobe_on_fall; $changed(pixel_valid_strobe) |-> $fell(dot_clock); endproperty
  property p_data_on_fall; $changed(rgb_data) |-> $fell(dot_clock); endproperty
  property p_sync_width; $fell(line_sync) && seen_r |-> s_sync_one; endproperty
  property p_line_period; $fell(line_sync) && seen_r |-> lcnt_r == LINE_CYC; endproperty
  property p_active_count;
    $fell(line_sync) && seen_r |-> (scnt_r == 0) || (scnt_r == ACT_CYC);
  endproperty
  property p_blank_in_sync; !line_sync || !frame_sync |-> !pixel_valid_strobe; endproperty
  property p_frame_on_line; $fell(frame_sync) |-> $fell(line_sync); endproperty
  a_dot_high: assert property (p_dot_high)
    else $error("dot clock high phase wrong");
  a_dot_low: assert property (p_dot_low)
    else $error("dot clock low phase wrong");
  a_strobe_on_fall: assert property (p_strobe_on_fall)
    else $error("strobe moved off the dot fall");
  a_data_on_fall: assert property (p_data_on_fall)
    else $error("pixel data moved off the dot fall");
  a_sync_width: assert property (p_sync_width)
    else $error("line sync width wrong");
  a_line_period: assert property (p_line_period)
    else $error("line period wrong");
  a_active_count: assert property (p_active_count)
    else $error("active pixel count wrong");
  a_blank_in_sync: assert property (p_blank_in_sync)
    else $error("strobe high during sync");
  a_frame_on_line: assert property (p_frame_on_line)
    else $error("frame sync without line sync");
endmodule : rgb_link_props

// *** sim/rgb_panel_timing_interface_tb.sv ***
`timescale 1ns/10ps
module rgb_panel_timing_interface_tb
  import panel_pkg::*;
;
`define CHK(nm, ex, got) begin n_tests++; if ((got) !== (ex)) begin err_total++; \
  $display("[ERR] %s expected %h seen %h", nm, ex, got); end end
  // Clock, reset and bus master state
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [3:0] awaddr = '0, araddr = '0;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic [31:0] wdata = '0;
  logic [23:0] pixel_in = 24'hC3_5A96;
  logic s_awready, s_wready, s_bvalid, s_arready, s_rvalid, pixel_req;
  logic [1:0] s_bresp, s_rresp, resp;
  logic [31:0] s_rdata, rd;
  logic [23:0] pixel_out;
  logic pixel_out_valid, line_start, display_on;
  logic [VCNT_W-1:0] pixel_y;
  int err_total = 0, n_tests = 0, cnt;
  always #5 aclk = ~aclk; // 100 MHz
  rgb_link_if rgb_link_if_inst ();
  rgb_timing_drv #(.HALF_CYC(2)) rgb_timing_drv_inst (.aclk(aclk), .aresetn(aresetn),
    .s_awaddr(awaddr), .s_awvalid(awvalid), .s_awready(s_awready), .s_wdata(wdata),
    .s_wstrb(4'hF), .s_wvalid(wvalid), .s_wready(s_wready), .s_bresp(s_bresp),
    .s_bvalid(s_bvalid), .s_bready(bready), .s_araddr(araddr), .s_arvalid(arvalid),
    .s_arready(s_arready), .s_rdata(s_rdata), .s_rresp(s_rresp), .s_rvalid(s_rvalid),
    .s_rready(rready), .pixel_in(pixel_in), .pixel_req(pixel_req), .link(rgb_link_if_inst));
  // Syncs kept active low on both ends
  rgb_panel_rx rgb_panel_rx_inst (.aclk(aclk), .aresetn(aresetn), .link(rgb_link_if_inst),
    .hsync_active_high(1'b0), .vsync_active_high(1'b0), .pixel_out(pixel_out),
    .pixel_out_valid(pixel_out_valid), .pixel_x(), .pixel_y(pixel_y), .line_start(line_start),
    .frame_start(), .display_on(display_on));
  rgb_link_props #(.HALF(2)) rgb_link_props_inst (.aclk(aclk), .aresetn(aresetn),
    .rgb_data(rgb_link_if_inst.rgb_data), .dot_clock(rgb_link_if_inst.dot_clock),
    .standby_select(rgb_link_if_inst.standby_select), .line_sync(rgb_link_if_inst.line_sync),
    .frame_sync(rgb_link_if_inst.frame_sync),
    .pixel_valid_strobe(rgb_link_if_inst.pixel_valid_strobe));
  // Write one word; address and data offered together, each dropped when taken
  // Ready lines stay high between calls, so no call lowers what the next one raises
  task automatic axi_wr(input logic [3:0] a, input logic [31:0] d);
    int n;
    n = 0;
    awaddr <= a; awvalid <= 1'b1; wdata <= d; wvalid <= 1'b1; bready <= 1'b1;
    do begin
      @(posedge aclk); n++;
      if (awvalid && s_awready) awvalid <= 1'b0;
      if (wvalid && s_wready) wvalid <= 1'b0;
    end while (!(bready && s_bvalid) && n < 100);
    resp = s_bresp;
    // A response that never came counts against the run
    if (!s_bvalid) err_total++;
  endtask : axi_wr
  // Read one word; rready held until the data is seen
  task automatic axi_rd(input logic [3:0] a);
    int n;
    n = 0;
    araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
    do begin
      @(posedge aclk); n++;
      if (arvalid && s_arready) arvalid <= 1'b0;
    end while (!(rready && s_rvalid) && n < 100);
    rd = s_rdata;
    resp = s_rresp;
    if (!s_rvalid) err_total++;
  endtask : axi_rd
  // Count received pixels between two line starts; bounded by 10000 cycles, over two lines
  task automatic count_line();
    int n;
    n = 0; cnt = 0;
    while (!line_start && n < 5000) begin @(posedge aclk); n++; end
    do begin @(posedge aclk); n++; if (pixel_out_valid) cnt++; end
    while (!line_start && n < 10000);
  endtask : count_line
  // Values after reset, an unaligned address, and refused timing values
  task automatic t_regs();
    axi_rd(OFS_CTRL); `CHK("ctrl", 32'h0000_0000, rd)
    axi_rd(OFS_HTIM); `CHK("htim", 32'h002E_0014, rd)
    axi_rd(OFS_VTIM); `CHK("vtim", 32'h0017_000A, rd)
    axi_rd(OFS_STAT); `CHK("stat", 32'h0000_0000, rd)
    axi_rd(4'h2); `CHK("unmapped", RESP_SLVERR, resp)
    axi_wr(OFS_HTIM, 32'h002E_0029); axi_rd(OFS_HTIM); `CHK("hsync 41", 32'h002E_0014, rd)
    axi_wr(OFS_VTIM, 32'h0017_0015); axi_rd(OFS_VTIM); `CHK("vsync 21", 32'h0017_000A, rd)
    axi_wr(OFS_HTIM, 32'h002E_0001); `CHK("htim resp", RESP_OKAY, resp)
    axi_wr(OFS_VTIM, 32'h0001_0001); axi_rd(OFS_VTIM); `CHK("vtim", 32'h0001_0001, rd)
    $display("test regs done");
  endtask : t_regs
  // Run: a full active line, data on the wire and at the panel
  task automatic t_run();
    int n;
    n = 0;
    axi_wr(OFS_CTRL, 32'h0000_0003);
    // The pin follows the register one edge after the write lands
    @(posedge aclk);
    `CHK("standby select", 1'b1, rgb_link_if_inst.standby_select)
    while (!pixel_req && n < 20000) begin @(posedge aclk); n++; end
    // The requested pixel stands on the wire from the edge that took it
    @(posedge aclk);
    `CHK("strobe after req", 1'b1, rgb_link_if_inst.pixel_valid_strobe)
    `CHK("wire data", pixel_in, rgb_link_if_inst.rgb_data)
    count_line(); `CHK("pixels per line", 800, cnt)
    // Two active lines have ended by now, so the row count is two
    `CHK("row", 10'h002, pixel_y)
    `CHK("panel data", pixel_in, pixel_out)
    `CHK("display on", 1'b1, display_on)
    axi_rd(OFS_STAT); `CHK("stat run", 1'b1, rd[STAT_RUN])
    axi_wr(OFS_HTIM, 32'h002E_0002); axi_rd(OFS_HTIM); `CHK("htim frozen", 32'h002E_0001, rd)
    $display("test run done");
  endtask : t_run
  // Every colour depth, packed on the low lines
  task automatic t_modes();
    logic [23:0] ex;
    for (int m = 0; m < 4; m++) begin
      pixel_in <= 24'hA6_3CE9 + 24'(m);
      axi_wr(OFS_CTRL, 32'h0000_0003 | (32'(m) << CTRL_MODE_LSB));
      count_line();
      ex = pixel_in;
      if (m == 1) ex = {6'h00, pixel_in[23:18], pixel_in[15:10], pixel_in[7:2]};
      if (m == 2) ex = {8'h00, pixel_in[23:19], pixel_in[15:10], pixel_in[7:3]};
      `CHK("mode pixel", ex, pixel_out)
    end
    $display("test modes done");
  endtask : t_modes
  // Standby: panel drops every pixel of a whole line
  task automatic t_standby();
    axi_wr(OFS_CTRL, 32'h0000_0001);
    @(posedge aclk);
    `CHK("standby select", 1'b0, rgb_link_if_inst.standby_select)
    count_line(); count_line(); `CHK("standby pixels", 0, cnt)
    `CHK("display off", 1'b0, display_on)
    $display("test standby done");
  endtask : t_standby
  // Verdict and end of run
  task automatic conclude();
    $display("checks %0d mismatches %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : conclude
  // Main sequence
  initial begin
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    t_regs();
    t_run();
    t_modes();
    t_standby();
    conclude();
  end
  // Watchdog, about one and a half times the expected run
  initial begin
    repeat (100000) @(posedge aclk);
    err_total++;
    conclude();
  end
endmodule : rgb_panel_timing_interface_tb
